/* File: nvsram_host_pkg.sv */
// Constants and types for the nonvolatile SRAM host controller
package nvsram_host_pkg;

   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int SEQ_ADDR_W = 14;
   localparam int SEQ_STEPS = 6;
   localparam int CNT_W = 32;

   // Unlock addresses shared by both transfers, then the two final addresses
   localparam logic [0:4][ADDR_W-1:0] SEQ_COMMON = {
      15'h0E38, 15'h31C7, 15'h03E0, 15'h3C1F, 15'h303F};
   localparam logic [ADDR_W-1:0] SEQ_STORE_LAST = 15'h0FC0;
   localparam logic [ADDR_W-1:0] SEQ_RECALL_LAST = 15'h0C63;
   localparam logic [2:0] SEQ_LAST_STEP = 3'h5;

   // Timing figures in their own units; defaults only, the device part sets them
   localparam int CLK_PERIOD_NS = 20;
   localparam int STROBE_NS = 100;
   localparam int SAVE_DURATION_US = 10000;
   localparam int RESTORE_DURATION_US = 20;
   localparam int POWERUP_RESTORE_DURATION_US = 20000;

   // Waits are least times, so they round up
   localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAVE_CYCLES =
      (SAVE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTORE_CYCLES =
      (RESTORE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWERUP_CYCLES =
      (POWERUP_RESTORE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_STORE, OP_RECALL} host_op_t;

   typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD,
      ST_NV_WAIT} host_state_t;

endpackage

/* File: nvsram_store_recall_control.sv */
// Host-side controller driving the pins of a nonvolatile SRAM
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Store: five common reads then 0x0FC0
// - Recall: five common reads then 0x0C63
// - Unlock steps are reads, write enable high
// - Never hold write state at power-up recall end
// - Read: chip and output enable low, write high
// - Write: chip and write enable low, address stable
module nvsram_store_recall_control
   import nvsram_host_pkg::*;
#(
   parameter int unsigned STROBE_LEN = STROBE_CYCLES,
   parameter int unsigned SAVE_LEN = SAVE_CYCLES,
   parameter int unsigned RESTORE_LEN = RESTORE_CYCLES,
   parameter int unsigned POWERUP_LEN = POWERUP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire host_op_t cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_wdata,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic cmd_refused,
   output logic busy,
   input wire logic supply_ok,
   output logic [ADDR_W-1:0] byte_address,
   input wire logic [DATA_W-1:0] data_lines_i,
   output logic [DATA_W-1:0] data_lines_o,
   output logic data_lines_oe,
   output logic chip_enable_n,
   output logic write_enable_n,
   output logic output_enable_n
);

   typedef struct packed {
      host_state_t state;
      host_op_t op;
      logic [2:0] step;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic rsp_valid;
      logic refused;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic dq_oe;
      logic [1:0] sup_sync;
      logic sup_prev;
      logic [DATA_W-1:0] dq_meta;
      logic [DATA_W-1:0] dq_sync;
   } ctrl_t;

   ctrl_t st_q;
   ctrl_t st_d;
   logic supply_good;
   logic is_seq;

   assign supply_good = st_q.sup_sync[1];
   assign is_seq = (st_q.op == OP_STORE) || (st_q.op == OP_RECALL);
   assign cmd_ready = (st_q.state == ST_IDLE);

   function automatic logic [ADDR_W-1:0] seq_addr(input host_op_t op, input logic [2:0] step);
      logic [ADDR_W-1:0] a;
      a = '0;
      if (step == SEQ_LAST_STEP) begin
         a = (op == OP_STORE) ? SEQ_STORE_LAST : SEQ_RECALL_LAST;
      end else begin
         a = SEQ_COMMON[step];
      end
      // Top bit is not decoded by the device; drive it low for a clean pattern
      a[ADDR_W-1] = 1'b0;
      return a;
   endfunction

   always_comb begin
      st_d = st_q;
      st_d.sup_sync = {st_q.sup_sync[0], supply_ok};
      st_d.sup_prev = supply_good;
      st_d.dq_meta = data_lines_i;
      st_d.dq_sync = st_q.dq_meta;
      st_d.rsp_valid = 1'b0;
      st_d.refused = 1'b0;
      unique case (st_q.state)
         ST_POWERUP: begin
            // Bus parked with chip deselected so no write is live at recall end
            st_d.ce_n = 1'b1;
            st_d.we_n = 1'b1;
            st_d.oe_n = 1'b1;
            st_d.dq_oe = 1'b0;
            st_d.step = '0;
            if (!supply_good) begin
               st_d.cnt = 32'(POWERUP_LEN);
            end else if (st_q.cnt <= 32'h1) begin
               st_d.state = ST_IDLE;
            end else begin
               st_d.cnt = st_q.cnt - 32'h1;
            end
         end
         ST_IDLE: begin
            if (cmd_valid) begin
               st_d.op = cmd_op;
               st_d.addr = cmd_addr;
               st_d.wdata = cmd_wdata;
               st_d.step = '0;
               if (!supply_good && (cmd_op == OP_WRITE || cmd_op == OP_STORE)) begin
                  st_d.refused = 1'b1;
               end else begin
                  st_d.state = ST_SETUP;
                  if (cmd_op == OP_STORE || cmd_op == OP_RECALL) begin
                     st_d.addr = seq_addr(cmd_op, 3'h0);
                  end
                  st_d.dq_oe = (cmd_op == OP_WRITE);
               end
            end
         end
         ST_SETUP: begin
            // Address settles one cycle before chip enable falls
            st_d.state = ST_STROBE;
            st_d.ce_n = 1'b0;
            st_d.cnt = 32'(STROBE_LEN);
            if (st_q.op == OP_WRITE) begin
               st_d.we_n = 1'b0;
               st_d.oe_n = 1'b1;
            end else begin
               st_d.we_n = 1'b1;
               st_d.oe_n = 1'b0;
            end
         end
         ST_STROBE: begin
            if (st_q.cnt <= 32'h1) begin
               st_d.state = ST_HOLD;
               st_d.ce_n = 1'b1;
               st_d.we_n = 1'b1;
               st_d.oe_n = 1'b1;
               st_d.rdata = st_q.dq_sync;
            end else begin
               st_d.cnt = st_q.cnt - 32'h1;
            end
         end
         ST_HOLD: begin
            // Address and data held one cycle past the enables
            st_d.dq_oe = 1'b0;
            if (!is_seq) begin
               st_d.state = ST_IDLE;
               st_d.rsp_valid = 1'b1;
            end else if (st_q.step == SEQ_LAST_STEP) begin
               st_d.state = ST_NV_WAIT;
               st_d.cnt = (st_q.op == OP_STORE) ? 32'(SAVE_LEN) : 32'(RESTORE_LEN);
               st_d.step = '0;
            end else begin
               // No other access is let in between steps
               st_d.state = ST_SETUP;
               st_d.step = st_q.step + 3'h1;
               st_d.addr = seq_addr(st_q.op, st_q.step + 3'h1);
            end
         end
         ST_NV_WAIT: begin
            // Device is busy erasing/programming or clearing/copying
            if (st_q.cnt <= 32'h1) begin
               st_d.state = ST_IDLE;
               st_d.rsp_valid = 1'b1;
            end else begin
               st_d.cnt = st_q.cnt - 32'h1;
            end
         end
         default: st_d.state = ST_POWERUP;
      endcase
      // A supply dip means the device will recall again; wait it out
      if (supply_good && !st_q.sup_prev && st_q.state != ST_POWERUP) begin
         st_d.state = ST_POWERUP;
         st_d.cnt = 32'(POWERUP_LEN);
         st_d.ce_n = 1'b1;
         st_d.we_n = 1'b1;
         st_d.oe_n = 1'b1;
         st_d.dq_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q <= '{state: ST_POWERUP, op: OP_READ, step: 3'h0, cnt: 32'(POWERUP_LEN),
            addr: '0, wdata: '0, rdata: '0, rsp_valid: 1'b0, refused: 1'b0,
            ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0, sup_sync: 2'h0,
            sup_prev: 1'b0, dq_meta: '0, dq_sync: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign rsp_valid = st_q.rsp_valid;
   assign rsp_rdata = st_q.rdata;
   assign cmd_refused = st_q.refused;
   assign busy = (st_q.state != ST_IDLE);
   assign byte_address = st_q.addr;
   assign data_lines_o = st_q.wdata;
   assign data_lines_oe = st_q.dq_oe;
   assign chip_enable_n = st_q.ce_n;
   assign write_enable_n = st_q.we_n;
   assign output_enable_n = st_q.oe_n;

   sequence s_seq_strobe;
      (st_q.state == ST_STROBE) && is_seq;
   endsequence

   sequence s_cycle_end;
      $rose(chip_enable_n);
   endsequence

   AST_SEQ_IS_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_seq_strobe |-> write_enable_n && !chip_enable_n)
      else $error("unlock step not a read");

   AST_SEQ_TOP_BIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_seq_strobe |-> byte_address[ADDR_W-1] == 1'b0)
      else $error("unlock address top bit set");

   AST_SEQ_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q.state == ST_SETUP && is_seq && st_q.step == 3'h0)
      |-> byte_address == 15'h0E38)
      else $error("unlock sequence bad first address");

   AST_STORE_LAST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_seq_strobe and (st_q.op == OP_STORE && st_q.step == SEQ_LAST_STEP))
      |-> byte_address == 15'h0FC0)
      else $error("store final address wrong");

   AST_RECALL_LAST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_seq_strobe and (st_q.op == OP_RECALL && st_q.step == SEQ_LAST_STEP))
      |-> byte_address == 15'h0C63)
      else $error("recall final address wrong");

   AST_ADDR_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_cycle_end |-> $stable(byte_address))
      else $error("address moved at end of cycle");

   AST_WRITE_NO_OE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!write_enable_n) |-> !chip_enable_n && output_enable_n && data_lines_oe)
      else $error("write cycle with output enable or no data");

   AST_READ_PINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q.state == ST_STROBE && st_q.op == OP_READ)
      |-> !output_enable_n && write_enable_n && !data_lines_oe)
      else $error("read cycle pins wrong");

   AST_POWERUP_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q.state == ST_POWERUP) |-> ##1 (write_enable_n && chip_enable_n))
      else $error("bus active during power-up recall");

   AST_LOW_SUPPLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd_valid && cmd_ready && !supply_good && cmd_op == OP_WRITE)
      |=> cmd_refused ##1 (st_q.state == ST_IDLE && write_enable_n))
      else $error("write not refused under low supply");

   AST_NV_DESELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q.state == ST_NV_WAIT) |-> chip_enable_n [*2])
      else $error("device touched during nonvolatile cycle");

endmodule // nvsram_store_recall_control
`default_nettype wire

/* File: nvsram_device_model.sv */
// Behavioural model of the nonvolatile SRAM as seen at its pins
`timescale 1ns/1ps
`default_nettype none
module nvsram_device_model
   import nvsram_host_pkg::*;
#(
   parameter int SAVE_NS = 380,
   parameter int RESTORE_NS = 300
) (
   input wire logic supply_ok,
   input wire logic [ADDR_W-1:0] byte_address,
   input wire logic [DATA_W-1:0] data_lines_o,
   input wire logic data_lines_oe,
   input wire logic chip_enable_n,
   input wire logic write_enable_n,
   input wire logic output_enable_n,
   output logic [DATA_W-1:0] data_lines_i
);
   logic [DATA_W-1:0] sram [0:32767];
   logic [DATA_W-1:0] nv [0:32767];
   logic dis = 1'b1;
   logic wr = 1'b0;
   logic was_wr;
   int step = 0;
   initial foreach (nv[i]) nv[i] = ~i[7:0];
   // Undriven pins show the inverse byte so stale data never passes for a read
   assign data_lines_i = (!dis && !chip_enable_n && !output_enable_n && write_enable_n) ?
      sram[byte_address] : ~sram[byte_address];
   task automatic transfer(input bit to_nv, input int ns);
      dis = 1'b1;
      step = 0;
      if (to_nv) begin
         foreach (nv[i]) nv[i] = '1;
         foreach (nv[i]) nv[i] = sram[i];
      end else begin
         foreach (sram[i]) sram[i] = '0;
         foreach (sram[i]) sram[i] = nv[i];
      end
      #(ns) dis = 1'b0;
   endtask
   always @(posedge supply_ok) transfer(1'b0, RESTORE_NS);
   // Set unconditionally: the strobe may fall in the same step as chip enable
   always @(negedge write_enable_n) wr = 1'b1;
   always @(posedge chip_enable_n) begin
      was_wr = wr;
      wr = 1'b0;
      if (!dis) begin
         if (was_wr) begin
            step = 0;
            if (supply_ok && data_lines_oe) sram[byte_address] = data_lines_o;
         end else if (step == 5 && byte_address[13:0] == SEQ_STORE_LAST[13:0]) begin
            if (supply_ok) transfer(1'b1, SAVE_NS);
            else step = 0;
         end else if (step == 5 && byte_address[13:0] == SEQ_RECALL_LAST[13:0]) begin
            transfer(1'b0, RESTORE_NS);
         end else if (step < 5 && byte_address[13:0] == SEQ_COMMON[step][13:0]) begin
            step++;
         end else begin
            step = (byte_address[13:0] == SEQ_COMMON[0][13:0]) ? 1 : 0;
         end
      end
   end
endmodule // nvsram_device_model
`default_nettype wire

/* File: nvsram_store_recall_control_tb.sv */
// Self-checking testbench for the nonvolatile SRAM host controller
`timescale 1ns/1ps
`default_nettype none
module nvsram_store_recall_control_tb
   import nvsram_host_pkg::*;
;
   logic clk_sys, rst_n, cmd_valid, cmd_ready, rsp_valid, cmd_refused, busy, supply_ok;
   logic data_lines_oe, chip_enable_n, write_enable_n, output_enable_n, f;
   host_op_t cmd_op;
   logic [ADDR_W-1:0] cmd_addr, byte_address;
   logic [DATA_W-1:0] cmd_wdata, rsp_rdata, data_lines_i, data_lines_o, r;
   int error_cnt = 0;
   int n_compared = 0;
   nvsram_store_recall_control #(.SAVE_LEN(20), .RESTORE_LEN(20), .POWERUP_LEN(20)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .cmd_refused(cmd_refused), .busy(busy), .supply_ok(supply_ok),
      .byte_address(byte_address), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .chip_enable_n(chip_enable_n),
      .write_enable_n(write_enable_n), .output_enable_n(output_enable_n));
   nvsram_device_model u_mem (
      .supply_ok(supply_ok), .byte_address(byte_address), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .chip_enable_n(chip_enable_n),
      .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
      .data_lines_i(data_lines_i));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   // Request held until the edge that sees ready, answer taken on a settled half cycle
   task automatic cmd(input host_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      do @(negedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 5000);
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      do @(negedge clk_sys); while (rsp_valid !== 1'b1 && cmd_refused !== 1'b1 && ++n < 5000);
      r = rsp_rdata;
      f = cmd_refused;
      if (n >= 5000) check("response", 8'h01, 8'h00);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      cmd(OP_READ, a, 8'h00);
      check("read data", e, r);
   endtask
   task automatic t_powerup();
      supply_ok <= 1'b1;
      rd(15'h0005, 8'hFA);
      $display("test powerup done");
   endtask
   task automatic t_rw();
      cmd(OP_WRITE, 15'h1234, 8'hA5);
      cmd(OP_WRITE, 15'h7FFF, 8'h3C);
      rd(15'h1234, 8'hA5);
      rd(15'h7FFF, 8'h3C);
      $display("test read write done");
   endtask
   task automatic t_store_recall();
      cmd(OP_WRITE, 15'h0100, 8'hC3);
      cmd(OP_STORE, 15'h0000, 8'h00);
      check("store refused", 8'h00, {7'h00, f});
      cmd(OP_WRITE, 15'h0100, 8'h11);
      rd(15'h0100, 8'h11);
      for (int i = 0; i < 2; i++) begin
         cmd(OP_RECALL, 15'h0000, 8'h00);
         rd(15'h0100, 8'hC3);
         rd(15'h0101, 8'hFE);
         cmd(OP_WRITE, 15'h0100, 8'h22);
      end
      $display("test store recall done");
   endtask
   task automatic t_low_supply();
      supply_ok <= 1'b0;
      repeat (5) @(posedge clk_sys);
      cmd(OP_WRITE, 15'h0200, 8'h77);
      check("write refused", 8'h01, {7'h00, f});
      cmd(OP_STORE, 15'h0000, 8'h00);
      check("store refused", 8'h01, {7'h00, f});
      // Refused write leaves the byte recalled at power-up in place
      rd(15'h0200, 8'hFF);
      supply_ok <= 1'b1;
      // Rising supply must reach the controller first, or the next request is cut off
      repeat (4) @(negedge clk_sys);
      check("supply rise busy", 8'h01, {7'h00, busy});
      rd(15'h0100, 8'hC3);
      rd(15'h0200, 8'hFF);
      $display("test low supply done");
   endtask
   initial begin
      #(20 * 20000);
      error_cnt++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      results();
   end
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_addr = '0;
      cmd_wdata = '0;
      supply_ok = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_powerup();
      t_rw();
      t_store_recall();
      t_low_supply();
      results();
   end
endmodule // nvsram_store_recall_control_tb
`default_nettype wire
